// >>> rtl/gpio_pkg.sv
// Purpose: shared constants and types for the three-pin gpio port and its serial register access
// Assumes: 8-bit registers, 7-bit serial device address
// Notes:   register offsets, the dimming select bit position and register reset values live here
`default_nettype none
package gpio_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_DIRECTION_CONTROL = 8'h06;
    localparam logic [7:0] ADDR_PIN_DATA              = 8'h07;

    localparam int         PIN_COUNT          = 3;
    localparam int         DIM_SELECT_BIT     = 4;
    localparam logic [2:0] DIR_RESET          = 3'h0;
    localparam logic [2:0] DATA_RESET         = 3'h0;
    localparam logic       DIM_SELECT_RESET   = 1'b0;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;

    // ------------------------------------------------------------
    // serial interface
    // ------------------------------------------------------------
    localparam logic [6:0] DEVICE_ADDRESS     = 7'h59;
    localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
    localparam logic [3:0] LAST_READ_BIT      = 4'h7;
    localparam logic [1:0] LINE_IDLE          = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE       = 4'h0,
        ST_ADDR       = 4'h1,
        ST_ADDR_ACK   = 4'h2,
        ST_REG        = 4'h3,
        ST_REG_ACK    = 4'h4,
        ST_WDATA      = 4'h5,
        ST_WDATA_ACK  = 4'h6,
        ST_RDATA      = 4'h7,
        ST_RDATA_ACK  = 4'h8
    } serial_state_t;

    // pin drive bundle: enable and level for each pin
    typedef struct packed {
        logic [PIN_COUNT-1:0] oe;
        logic [PIN_COUNT-1:0] value;
    } pin_drive_t;

endpackage
`default_nettype wire

// >>> rtl/pin_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to i_clk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             i_clk,     // core clock
    input  wire logic             i_reset_n, // async reset, active low
    input  wire logic [WIDTH-1:0] i_d,       // asynchronous inputs
    output logic      [WIDTH-1:0] o_q        // filtered synchronous levels
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
        end else begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a one-cycle glitch caught by stage two never reaches the output
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_q <= RESET_VAL;
        end else begin
            o_q <= (o_q & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
        end
    end

    chk_sync_agree_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        ((o_q ^ $past(o_q)) & ($past(s2_reg) ^ $past(s3_reg))) == '0)
        else $error("synchroniser output moved while stages disagreed");

endmodule
`default_nettype wire

// >>> rtl/gpio_port.sv
// Purpose: three-pin general purpose port with dimming input select, reached over a two-wire serial slave
// Assumes: scl and sda are slow against i_clk; sda is open drain, pulled up outside
// Notes:   rules carried out by this block follow
`timescale 1ns/10ps
`default_nettype none
module gpio_port #(
    parameter logic [6:0] SLAVE_ADDRESS = gpio_pkg::DEVICE_ADDRESS
) (
    input  wire logic       i_clk,       // core clock, 250 MHz
    input  wire logic       i_reset_n,   // async reset, active low
    input  wire logic       i_scl,       // serial clock pin
    input  wire logic       i_sda,       // serial data pin level
    output logic            o_sda_out,   // serial data drive level, always low
    output logic            o_sda_oe,    // high while pulling sda low
    input  wire logic [2:0] i_gpio_in,   // pin levels
    output logic      [2:0] o_gpio_out,  // pin drive levels
    output logic      [2:0] o_gpio_oe,   // pin drive enables
    output logic            o_dim_en,    // dimming input selected on pin 0
    output logic            o_dim_level  // dimming level, high means lights on
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_sync;
    logic [1:0] line_sync;

    pin_sync3 #(.WIDTH(3), .RESET_VAL(3'h0)) u_pin_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_d       (i_gpio_in),
        .o_q       (pin_sync)
    );

    pin_sync3 #(.WIDTH(2), .RESET_VAL(gpio_pkg::LINE_IDLE)) u_line_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_d       ({i_scl, i_sda}),
        .o_q       (line_sync)
    );

    // ------------------------------------------------------------
    // line event detection
    // ------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    assign scl_s = line_sync[1];
    assign sda_s = line_sync[0];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_prev_reg;
    assign scl_fall   = ~scl_s & scl_prev_reg;
    assign start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_seen  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    gpio_pkg::serial_state_t state_reg;
    logic [2:0]              dir_reg;
    logic                    dim_sel_reg;
    logic [2:0]              data_reg;
    logic [7:0]              shift_reg;
    logic [7:0]              ptr_reg;
    logic                    reg_wr;
    logic [7:0]              read_byte;

    // commit on the rising scl edge inside the final acknowledge
    assign reg_wr = (state_reg == gpio_pkg::ST_WDATA_ACK) && scl_rise && !start_seen && !stop_seen;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dir_reg     <= gpio_pkg::DIR_RESET;
            dim_sel_reg <= gpio_pkg::DIM_SELECT_RESET;
            data_reg    <= gpio_pkg::DATA_RESET;
        end else if (reg_wr) begin
            if (ptr_reg == gpio_pkg::ADDR_PIN_DIRECTION_CONTROL) begin
                dir_reg     <= shift_reg[2:0];
                dim_sel_reg <= shift_reg[gpio_pkg::DIM_SELECT_BIT];
            end else if (ptr_reg == gpio_pkg::ADDR_PIN_DATA) begin
                data_reg    <= shift_reg[2:0];
            end
        end
    end

    always_comb begin
        unique case (ptr_reg)
            gpio_pkg::ADDR_PIN_DIRECTION_CONTROL: read_byte = {3'h0, dim_sel_reg, 1'b0, dir_reg};
            gpio_pkg::ADDR_PIN_DATA:              read_byte = {5'h00, pin_sync};
            default:                              read_byte = gpio_pkg::UNMAPPED_READ;
        endcase
    end

    // ------------------------------------------------------------
    // pin drive and dimming outputs
    // ------------------------------------------------------------
    gpio_pkg::pin_drive_t drive_next;

    always_comb begin
        drive_next.value = data_reg;
        drive_next.oe    = dir_reg;
        drive_next.oe[0] = dir_reg[0] & ~dim_sel_reg;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_gpio_out <= gpio_pkg::DATA_RESET;
            o_gpio_oe  <= gpio_pkg::DIR_RESET;
        end else begin
            o_gpio_out <= drive_next.value;
            o_gpio_oe  <= drive_next.oe;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dim_en    <= 1'b0;
            o_dim_level <= 1'b0;
        end else begin
            o_dim_en    <= dim_sel_reg;
            o_dim_level <= dim_sel_reg & pin_sync[0];
        end
    end

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    logic [3:0] bit_cnt_reg;
    logic [7:0] tx_reg;
    logic       byte_done;

    assign byte_done = scl_fall && (bit_cnt_reg == gpio_pkg::BITS_PER_BYTE);
    assign o_sda_out = 1'b0;

    // sda only changes after an scl fall, so hold time to the master is the sync delay
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg   <= gpio_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            ptr_reg     <= 8'h00;
            tx_reg      <= 8'h00;
            o_sda_oe    <= 1'b0;
        end else if (start_seen) begin
            state_reg   <= gpio_pkg::ST_ADDR;
            bit_cnt_reg <= 4'h0;
            o_sda_oe    <= 1'b0;
        end else if (stop_seen) begin
            state_reg   <= gpio_pkg::ST_IDLE;
            o_sda_oe    <= 1'b0;
        end else begin
            unique case (state_reg)
                gpio_pkg::ST_IDLE: begin
                    o_sda_oe <= 1'b0;
                end
                gpio_pkg::ST_ADDR, gpio_pkg::ST_REG, gpio_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == gpio_pkg::ST_ADDR) begin
                            if (shift_reg[7:1] == SLAVE_ADDRESS) begin
                                state_reg <= gpio_pkg::ST_ADDR_ACK;
                                o_sda_oe  <= 1'b1;
                            end else begin
                                state_reg <= gpio_pkg::ST_IDLE;
                            end
                        end else if (state_reg == gpio_pkg::ST_REG) begin
                            ptr_reg   <= shift_reg;
                            state_reg <= gpio_pkg::ST_REG_ACK;
                            o_sda_oe  <= 1'b1;
                        end else begin
                            state_reg <= gpio_pkg::ST_WDATA_ACK;
                            o_sda_oe  <= 1'b1;
                        end
                    end
                end
                gpio_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (shift_reg[0]) begin
                            state_reg <= gpio_pkg::ST_RDATA;
                            tx_reg    <= read_byte;
                            o_sda_oe  <= ~read_byte[7];
                        end else begin
                            state_reg <= gpio_pkg::ST_REG;
                            o_sda_oe  <= 1'b0;
                        end
                    end
                end
                gpio_pkg::ST_REG_ACK, gpio_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_reg <= gpio_pkg::ST_WDATA;
                        o_sda_oe  <= 1'b0;
                    end
                end
                gpio_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == gpio_pkg::LAST_READ_BIT) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= gpio_pkg::ST_RDATA_ACK;
                            o_sda_oe    <= 1'b0;
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            tx_reg      <= {tx_reg[6:0], 1'b0};
                            o_sda_oe    <= ~tx_reg[6];
                        end
                    end
                end
                gpio_pkg::ST_RDATA_ACK: begin
                    if (scl_rise && sda_s) begin
                        state_reg <= gpio_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        state_reg <= gpio_pkg::ST_RDATA;
                        tx_reg    <= read_byte;
                        o_sda_oe  <= ~read_byte[7];
                    end
                end
                default: begin
                    state_reg <= gpio_pkg::ST_IDLE;
                    o_sda_oe  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_ctrl_commit;
        reg_wr && (ptr_reg == gpio_pkg::ADDR_PIN_DIRECTION_CONTROL);
    endsequence

    chk_dir_pin0_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_ctrl_commit ##2 1'b1 |-> o_gpio_oe[0] == ($past(shift_reg[0], 2) & ~$past(shift_reg[4], 2)))
        else $error("pin 0 enable does not follow written control byte");

    chk_dim_forces_input: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        dim_sel_reg |=> !o_gpio_oe[0])
        else $error("pin 0 driven while dimming input selected");

    chk_out_follows_data: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (reg_wr && ptr_reg == gpio_pkg::ADDR_PIN_DATA) ##2 1'b1 |-> o_gpio_out == $past(shift_reg[2:0], 2))
        else $error("output level does not follow data write");

    chk_read_live_pins: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_reg == gpio_pkg::ST_ADDR_ACK && scl_fall && shift_reg[0] && !start_seen && !stop_seen
         && ptr_reg == gpio_pkg::ADDR_PIN_DATA) |=> tx_reg[2:0] == $past(pin_sync))
        else $error("data read does not return pin levels");

    chk_pins12_plain: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_gpio_oe[2:1] == $past(dir_reg[2:1]))
        else $error("pins 1 and 2 enables not set by direction bits alone");

    chk_dim_active_high: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_dim_level == ($past(dim_sel_reg) & $past(pin_sync[0])))
        else $error("dimming level wrong polarity or not gated by select");

    chk_commit_at_ack: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $changed(data_reg) |-> $past(reg_wr))
        else $error("data register changed outside final acknowledge");

    chk_ctrl_written: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_ctrl_commit |=> dim_sel_reg == $past(shift_reg[4]) && dir_reg == $past(shift_reg[2:0]))
        else $error("control register not updated at acknowledge");

endmodule
`default_nettype wire

// >>> bench/pin_partner.sv
// Purpose: external circuit on the three port pins, seen from outside the device
// Assumes: pins have no pull resistor; the device drives a pin only while its enable is high
// Notes:   the partner drives every pin that the device leaves as an input, never fighting it
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
    input  wire logic [2:0] i_drive_out,  // device drive levels
    input  wire logic [2:0] i_drive_oe,   // device drive enables
    input  wire logic [2:0] i_ext_level,  // level the outside circuit applies
    output logic      [2:0] o_pin_level   // resolved pin levels
);
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // the partner backs off wherever the device drives, so no pin ever sees contention
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            o_pin_level[i] = i_drive_oe[i] ? i_drive_out[i] : i_ext_level[i];
        end
    end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: self-checking bench for the three-pin port and its serial register access
// Assumes: serial master runs slow phases of 16 core clocks, far above the synchroniser delay
// Notes:   all expectations come from the register map constants and the pin rules
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int H = 16;
    logic       i_clk     = 1'b0;
    logic       i_reset_n = 1'b0;
    logic       scl       = 1'b1;
    logic       sda_m     = 1'b1;
    logic [2:0] ext_lvl   = 3'h5;
    logic       sda_w;
    logic       sda_oe;
    logic       sda_out;
    logic       dim_en;
    logic       dim_lvl;
    logic [2:0] pin_w;
    logic [2:0] g_out;
    logic [2:0] g_oe;
    logic [2:0] pre_oe;
    logic [2:0] pre_out;
    int         num_errors = 0;
    int         num_checks = 0;

    // open-drain wire: high unless master or device pulls it low
    assign sda_w = sda_m & ~(sda_oe & ~sda_out);
    always #2 i_clk = ~i_clk;

    gpio_port dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda_w),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_gpio_in(pin_w), .o_gpio_out(g_out),
        .o_gpio_oe(g_oe), .o_dim_en(dim_en), .o_dim_level(dim_lvl)
    );
    pin_partner peer (
        .i_drive_out(g_out), .i_drive_oe(g_oe), .i_ext_level(ext_lvl), .o_pin_level(pin_w)
    );

    // ------------------------------------------------------------
    // serial master tasks
    // ------------------------------------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bit_io(input logic b, output logic r);
        @(posedge i_clk);
        sda_m <= b;
        wt(H);
        pre_oe  = g_oe;
        pre_out = g_out;
        scl <= 1'b1;
        wt(H);
        r = sda_w;
        scl <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(1'b1, ack);
    endtask
    task automatic start_c();
        @(posedge i_clk);
        sda_m <= 1'b1;
        wt(H);
        scl <= 1'b1;
        wt(H);
        sda_m <= 1'b0;
        wt(H);
        scl <= 1'b0;
    endtask
    task automatic stop_c();
        @(posedge i_clk);
        sda_m <= 1'b0;
        wt(H);
        scl <= 1'b1;
        wt(H);
        sda_m <= 1'b1;
        wt(H);
    endtask
    task automatic head(input logic [7:0] a);
        logic [7:0] q;
        logic       ack;
        start_c();
        byte_io({gpio_pkg::DEVICE_ADDRESS, 1'b0}, q, ack);
        chk(8'(ack), 8'h00);
        byte_io(a, q, ack);
        chk(8'(ack), 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       ack;
        head(a);
        byte_io(d, q, ack);
        chk(8'(ack), 8'h00);
        stop_c();
        wt(4);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic ack;
        head(a);
        start_c();
        byte_io({gpio_pkg::DEVICE_ADDRESS, 1'b1}, q, ack);
        chk(8'(ack), 8'h00);
        // master answers the single data byte with a release, ending the read
        byte_io(8'hFF, q, ack);
        stop_c();
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [7:0] q;
        logic       ack;
        logic [2:0] dd;
        wt(8);
        i_reset_n <= 1'b1;
        wt(8);
        chk(8'(g_oe), 8'h00);
        chk(8'(g_out), 8'h00);
        chk(8'(dim_en), 8'h00);
        // pin 0 is high from outside but the select is off, so no dimming level
        chk(8'(dim_lvl), 8'h00);
        rd(gpio_pkg::ADDR_PIN_DIRECTION_CONTROL, q);
        chk(q, 8'h00);
        rd(gpio_pkg::ADDR_PIN_DATA, q);
        chk(q, 8'h05);
        wr(gpio_pkg::ADDR_PIN_DATA, 8'hFE);
        chk(8'(pre_out), 8'h00);
        chk(8'(g_out), 8'h06);
        // every direction pattern; reads mix driven and external levels
        for (int d = 0; d < 8; d++) begin
            dd = d[2:0];
            wr(gpio_pkg::ADDR_PIN_DIRECTION_CONTROL, 8'(dd));
            chk(8'(pre_oe), (d == 0) ? 8'h00 : 8'(dd - 3'h1));
            chk(8'(g_oe), 8'(dd));
            chk(8'(dim_en), 8'h00);
            rd(gpio_pkg::ADDR_PIN_DATA, q);
            chk(q, 8'((dd & 3'h6) | (~dd & 3'h5)));
        end
        wr(gpio_pkg::ADDR_PIN_DIRECTION_CONTROL, 8'hFF);
        chk(8'(g_oe), 8'h06);
        chk(8'(dim_en), 8'h01);
        rd(gpio_pkg::ADDR_PIN_DIRECTION_CONTROL, q);
        chk(q, 8'h17);
        @(posedge i_clk);
        ext_lvl <= 3'h1;
        wt(8);
        chk(8'(dim_lvl), 8'h01);
        rd(gpio_pkg::ADDR_PIN_DATA, q);
        chk(q, 8'h07);
        @(posedge i_clk);
        ext_lvl <= 3'h0;
        wt(8);
        chk(8'(dim_lvl), 8'h00);
        rd(gpio_pkg::ADDR_PIN_DATA, q);
        chk(q, 8'h06);
        // unmapped pointer: write dropped, read gives the fill value
        wr(8'h08, 8'hFF);
        rd(8'h08, q);
        chk(q, gpio_pkg::UNMAPPED_READ);
        rd(gpio_pkg::ADDR_PIN_DIRECTION_CONTROL, q);
        chk(q, 8'h17);
        // foreign address: no acknowledge, no change
        start_c();
        byte_io({gpio_pkg::DEVICE_ADDRESS ^ 7'h01, 1'b0}, q, ack);
        stop_c();
        chk(8'(ack), 8'h01);
        chk(8'(g_out), 8'h06);
        close_out();
    end

    initial begin
        // the full sequence needs roughly 32000 cycles
        wt(50000);
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
